// *** cssd_board.sv ***
`timescale 1ns/1ns
// ****************************************************************
// Board model: strap resistor and clock sources.
// ****************************************************************
module cssd_board
   import cssd_pkg::*;
(
   // Clock.
   input  wire logic        sys_clk,
   // Strap level, changed by the bench only under reset.
   input  wire logic        strap_level,
   // Board outputs.
   output logic             clk_sel_strap,
   output cssd_clk_in_t     clk_in = '0
);
   logic [1:0] div_q = 2'h0;

   // Oscillator toggles every third cycle, the PLL every cycle.
   always @(posedge sys_clk) begin
      div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
      if (div_q == 2'h2) begin
         clk_in.osc_32k <= ~clk_in.osc_32k;
      end
      clk_in.ext_ref <= strap_level ? (clk_in.ext_ref ^ (div_q != 2'h0)) : 1'b0;
      clk_in.pll_out <= ~clk_in.pll_out;
   end

   // The strap is a steady level.
   assign clk_sel_strap = strap_level;
endmodule : cssd_board

// *** cssd_pkg.sv ***
package cssd_pkg;

   // ****************************************************************
   // Register map (register index, byte address is four times it)
   // ****************************************************************
   localparam logic [15:0] SLEW_CTRL_IDX   = 16'h1c16;
   localparam logic [15:0] SRC_REG_IDX     = 16'h1c20;
   localparam logic [15:0] STATUS3_IDX     = 16'h1c22;
   localparam logic [15:0] PLL_CFG_IDX     = 16'h1c24;
   localparam logic [15:0] GEN_STATUS_IDX  = 16'h1c26;
   localparam int          DISABLE_BIT_POS = 0;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [15:0] SLEW_RST = 16'h0000;
   localparam logic [1:0]  SRC_RST  = 2'h0;
   localparam logic [11:0] MULT_RST = 12'h001;

   // ****************************************************************
   // Frequencies and limits
   // ****************************************************************
   localparam longint OSC_HZ     = 32768;
   localparam longint REF0_HZ    = 11289600;
   localparam longint REF1_HZ    = 12000000;
   localparam longint REF2_HZ    = 12288000;
   localparam longint PLL_MAX_HZ = 120000000;
   localparam longint SPI_HZ     = 500000;
   localparam longint I2C_HZ     = 400000;

   // Largest multiplier per reference, rounded down so the limit holds.
   localparam logic [11:0] MULT_MAX_OSC  = 12'(PLL_MAX_HZ / OSC_HZ);
   localparam logic [11:0] MULT_MAX_REF0 = 12'(PLL_MAX_HZ / REF0_HZ);
   localparam logic [11:0] MULT_MAX_REF1 = 12'(PLL_MAX_HZ / REF1_HZ);
   localparam logic [11:0] MULT_MAX_REF2 = 12'(PLL_MAX_HZ / REF2_HZ);

   // Serial clock dividers, rounded up so the rate never exceeds target.
   localparam logic [15:0] SPI_DIV0 = 16'((REF0_HZ + SPI_HZ - 1) / SPI_HZ);
   localparam logic [15:0] SPI_DIV1 = 16'((REF1_HZ + SPI_HZ - 1) / SPI_HZ);
   localparam logic [15:0] SPI_DIV2 = 16'((REF2_HZ + SPI_HZ - 1) / SPI_HZ);
   localparam logic [15:0] I2C_DIV0 = 16'((REF0_HZ + I2C_HZ - 1) / I2C_HZ);
   localparam logic [15:0] I2C_DIV1 = 16'((REF1_HZ + I2C_HZ - 1) / I2C_HZ);
   localparam logic [15:0] I2C_DIV2 = 16'((REF2_HZ + I2C_HZ - 1) / I2C_HZ);

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef enum logic [1:0] {
      BOOT_IDLE    = 2'b00,
      BOOT_DISABLE = 2'b01,
      BOOT_CONFIG  = 2'b11,
      BOOT_DONE    = 2'b10
   } cssd_boot_t;

   typedef enum logic [1:0] {
      SRC_OSC = 2'h0,
      SRC_REF = 2'h1,
      SRC_PLL = 2'h2,
      SRC_GEN = 2'h3
   } cssd_src_t;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [15:0] address;
      logic [31:0] writedata;
   } cssd_bus_req_t;

   typedef struct packed {
      logic        osc_32k;
      logic        ext_ref;
      logic        pll_out;
   } cssd_clk_in_t;

   typedef struct packed {
      cssd_boot_t  boot;
      logic        strap_seen;
      logic        strap;
      logic        wait_req;
      logic [31:0] rdata;
      logic [1:0]  src;
      logic        disable_out;
      logic [11:0] mult;
      logic [15:0] slew;
      logic        bypass;
      logic [15:0] spi_div;
      logic [15:0] i2c_div;
      logic        dbg_out;
      logic        dbg_oe;
      logic        gen_ref;
      logic        rtc_clk;
   } cssd_state_t;

endpackage : cssd_pkg

// *** cssd_top.sv ***
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ns
module cssd_top
   import cssd_pkg::*;
#(
   parameter logic [1:0] BOOT_REF_SEL = 2'h0
) (
   // Clock and reset.
   input  wire logic          sys_clk,
   input  wire logic          sys_rst,
   // Board strap and sampled clocks.
   input  wire logic          clk_sel_strap,
   input  wire cssd_clk_in_t  clk_in,
   // Avalon-MM slave.
   input  wire cssd_bus_req_t avs_req,
   output logic               avs_waitrequest,
   output logic [31:0]        avs_readdata,
   // Debug clock pin.
   output logic               debug_clock_output_o,
   output logic               debug_clock_output_oe,
   // Generator controls.
   output logic               gen_ref_clk,
   output logic               rtc_timer_clk,
   output logic               pll_bypass,
   output logic [11:0]        pll_mult,
   output logic [15:0]        clock_output_slew_control,
   output logic [15:0]        spi_clk_div,
   output logic [15:0]        i2c_clk_div
);

   // ****************************************************************
   // Helper functions
   // ****************************************************************

   // Largest legal multiplier for the current reference.
   function automatic logic [11:0] mult_limit(input logic strap, input logic [1:0] sel);
      logic [11:0] lim;
      lim = MULT_MAX_OSC;
      if (strap) begin
         if (sel == 2'h0) begin
            lim = MULT_MAX_REF0;
         end else if (sel == 2'h1) begin
            lim = MULT_MAX_REF1;
         end else begin
            lim = MULT_MAX_REF2;
         end
      end
      return lim;
   endfunction : mult_limit

   // ****************************************************************
   // State update
   // ****************************************************************
   cssd_state_t s_q;
   cssd_state_t s_d;
   logic [15:0] idx;
   logic        req;
   logic        take;
   logic        sel_ref;

   assign idx  = {2'h0, avs_req.address[15:2]};
   assign req  = avs_req.read | avs_req.write;
   assign take = req & ~s_q.wait_req;

   // Next state of the whole block.
   always_comb begin
      s_d = s_q;
      sel_ref = 1'b0;
      // Strap is caught once, one cycle after reset release.
      if (!s_q.strap_seen) begin
         s_d.strap_seen = 1'b1;
         s_d.strap      = clk_sel_strap;
      end
      // Generator reference and timer clock selection.
      sel_ref = s_q.strap_seen & s_q.strap;
      s_d.gen_ref = sel_ref ? clk_in.ext_ref : clk_in.osc_32k;
      s_d.rtc_clk = clk_in.osc_32k;
      // Bus handshake: one wait cycle, then the access completes.
      s_d.wait_req = ~(req & s_q.wait_req);
      if (req & s_q.wait_req) begin
         s_d.rdata = 32'h0000_0000;
         if (idx == SLEW_CTRL_IDX) begin
            s_d.rdata = {16'h0000, s_q.slew};
         end else if (idx == SRC_REG_IDX) begin
            s_d.rdata = {30'h0000_0000, s_q.src};
         end else if (idx == STATUS3_IDX) begin
            s_d.rdata = {31'h0000_0000, s_q.disable_out};
         end else if (idx == PLL_CFG_IDX) begin
            s_d.rdata = {19'h0_0000, s_q.bypass, s_q.mult};
         end else if (idx == GEN_STATUS_IDX) begin
            s_d.rdata = {28'h000_0000, s_q.boot, s_q.strap, s_q.dbg_oe};
         end
      end
      if (take && avs_req.write) begin
         if (idx == SLEW_CTRL_IDX) begin
            s_d.slew = avs_req.writedata[15:0];
         end else if (idx == SRC_REG_IDX) begin
            s_d.src = avs_req.writedata[1:0];
         end else if (idx == STATUS3_IDX) begin
            s_d.disable_out = avs_req.writedata[DISABLE_BIT_POS];
         end else if (idx == PLL_CFG_IDX) begin
            s_d.bypass = avs_req.writedata[12];
            // Requests above the limit are clamped.
            if (avs_req.writedata[11:0] > mult_limit(s_q.strap, BOOT_REF_SEL)) begin
               s_d.mult = mult_limit(s_q.strap, BOOT_REF_SEL);
            end else begin
               s_d.mult = avs_req.writedata[11:0];
            end
         end
      end
      // Boot sequence; its set of the disable bit wins over a write.
      case (s_q.boot)
         BOOT_IDLE: begin
            if (s_q.strap_seen) begin
               s_d.boot = BOOT_DISABLE;
            end
         end
         BOOT_DISABLE: begin
            s_d.disable_out = 1'b1;
            s_d.boot        = BOOT_CONFIG;
         end
         BOOT_CONFIG: begin
            if (s_q.strap) begin
               s_d.bypass = 1'b1;
               if (BOOT_REF_SEL == 2'h0) begin
                  s_d.spi_div = SPI_DIV0;
                  s_d.i2c_div = I2C_DIV0;
               end else if (BOOT_REF_SEL == 2'h1) begin
                  s_d.spi_div = SPI_DIV1;
                  s_d.i2c_div = I2C_DIV1;
               end else begin
                  s_d.spi_div = SPI_DIV2;
                  s_d.i2c_div = I2C_DIV2;
               end
            end
            s_d.boot = BOOT_DONE;
         end
         default: begin
            s_d.boot = BOOT_DONE;
         end
      endcase
      // Debug pin source mux and enable.
      case (s_q.src)
         SRC_OSC: s_d.dbg_out = clk_in.osc_32k;
         SRC_REF: s_d.dbg_out = s_q.gen_ref;
         SRC_PLL: s_d.dbg_out = clk_in.pll_out;
         default: s_d.dbg_out = s_q.bypass ? s_q.gen_ref : clk_in.pll_out;
      endcase
      s_d.dbg_oe = ~s_d.disable_out;
   end

   // Registers of the block.
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         s_q <= '{boot: BOOT_IDLE, strap_seen: 1'b0, strap: 1'b0, wait_req: 1'b1,
                  rdata: 32'h0000_0000, src: SRC_RST, disable_out: 1'b0,
                  mult: MULT_RST, slew: SLEW_RST, bypass: 1'b0,
                  spi_div: 16'h0000, i2c_div: 16'h0000, dbg_out: 1'b0,
                  dbg_oe: 1'b1, gen_ref: 1'b0, rtc_clk: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************

   // Every output is a field of the state register.
   assign avs_waitrequest           = s_q.wait_req;
   assign avs_readdata              = s_q.rdata;
   assign debug_clock_output_o      = s_q.dbg_out;
   assign debug_clock_output_oe     = s_q.dbg_oe;
   assign gen_ref_clk               = s_q.gen_ref;
   assign rtc_timer_clk             = s_q.rtc_clk;
   assign pll_bypass                = s_q.bypass;
   assign pll_mult                  = s_q.mult;
   assign clock_output_slew_control = s_q.slew;
   assign spi_clk_div               = s_q.spi_div;
   assign i2c_clk_div               = s_q.i2c_div;

   // ****************************************************************
   // Assertions
   // ****************************************************************

   // Boot steps from reset release to the pin going off.
   sequence boot_start_s;
      $fell(sys_rst);
   endsequence

   sequence pin_on_then_off_s;
      debug_clock_output_oe [*3] ##1 !debug_clock_output_oe;
   endsequence

   // Expected boot dividers for each assumed reference rate, rounded up.
   localparam logic [15:0] BOOT_SPI_EXP = (BOOT_REF_SEL == 2'h0) ? 16'h0017 :
                                          ((BOOT_REF_SEL == 2'h1) ? 16'h0018 : 16'h0019);
   localparam logic [15:0] BOOT_I2C_EXP = (BOOT_REF_SEL == 2'h0) ? 16'h001d :
                                          ((BOOT_REF_SEL == 2'h1) ? 16'h001e : 16'h001f);

   a_osc_ref_low: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (s_q.strap_seen && !s_q.strap) |=> (gen_ref_clk == $past(clk_in.osc_32k)))
      else $error("generator reference not from oscillator");

   a_ext_ref_high: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (s_q.strap_seen && s_q.strap) |=> (gen_ref_clk == $past(clk_in.ext_ref)))
      else $error("generator reference not from external input");

   // Reset is part of the trigger, so the release edge, still in reset, is skipped.
   a_rtc_from_osc: assert property (@(posedge sys_clk) disable iff (sys_rst)
      !sys_rst |=> (rtc_timer_clk == $past(clk_in.osc_32k)))
      else $error("timer clock not from oscillator");

   a_src_pll_out: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (s_q.src == SRC_PLL) |=> (debug_clock_output_o == $past(clk_in.pll_out)))
      else $error("debug pin does not follow pll clock");

   // A completed write of the disable bit after boot sets the pin enable to its inverse.
   a_pin_disable: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (avs_req.write && !avs_waitrequest && idx == STATUS3_IDX && s_q.boot == BOOT_DONE)
      |=> (debug_clock_output_oe == !$past(avs_req.writedata[DISABLE_BIT_POS])))
      else $error("debug pin enable does not follow disable bit");

   a_boot_pin_off: assert property (@(posedge sys_clk)
      boot_start_s |-> pin_on_then_off_s)
      else $error("debug pin not turned off at boot start");

   a_boot_bypass: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (s_q.boot == BOOT_CONFIG && s_q.strap) |=> pll_bypass && spi_clk_div != 16'h0000)
      else $error("boot did not bypass pll on external reference");

   a_boot_divs: assert property (@(posedge sys_clk) disable iff (sys_rst)
      (s_q.boot == BOOT_CONFIG && s_q.strap)
      |=> (spi_clk_div == BOOT_SPI_EXP && i2c_clk_div == BOOT_I2C_EXP))
      else $error("boot serial dividers wrong");

   a_mult_limit: assert property (@(posedge sys_clk) disable iff (sys_rst)
      pll_mult <= mult_limit(s_q.strap, BOOT_REF_SEL))
      else $error("pll multiplier above limit");

endmodule : cssd_top

// *** tb_cssd_top.sv ***
`timescale 1ns/1ns
module tb_cssd_top
   import cssd_pkg::*;
();
   typedef struct packed {
      logic        wr;
      logic [15:0] idx;
      logic [31:0] wd;
      logic [31:0] ex;
   } cssd_row_t;
   logic          sys_clk = 1'b0;
   logic          sys_rst = 1'b1;
   logic          strap_level = 1'b0;
   logic          sel_strap;
   cssd_clk_in_t  clk_in, h1, h2;
   cssd_bus_req_t req = '0;
   logic          wait_r, oe, dbg, gref, rtc, byp;
   logic [31:0]   rdata, rd;
   logic [11:0]   mult;
   logic [15:0]   slew, spi, i2c;
   int            n_mismatch = 0;
   int            checked = 0;
   cssd_row_t     rows [11] = '{
      '{1'b0, SLEW_CTRL_IDX, 32'h0, 32'h0}, '{1'b0, SRC_REG_IDX, 32'h0, 32'h0},
      '{1'b0, PLL_CFG_IDX, 32'h0, 32'h1}, '{1'b0, GEN_STATUS_IDX, 32'h0, 32'h8},
      '{1'b0, STATUS3_IDX, 32'h0, 32'h1}, '{1'b1, SLEW_CTRL_IDX, 32'h1234, 32'h1234},
      '{1'b1, SRC_REG_IDX, 32'h2, 32'h2}, '{1'b1, PLL_CFG_IDX, 32'hfff, 32'he4e},
      '{1'b1, 16'h1c30, 32'hffff, 32'h0}, '{1'b1, GEN_STATUS_IDX, 32'hf, 32'h8},
      '{1'b1, STATUS3_IDX, 32'h0, 32'h0}};

   cssd_board board (.sys_clk(sys_clk), .strap_level(strap_level), .clk_sel_strap(sel_strap),
      .clk_in(clk_in));
   cssd_top uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_sel_strap(sel_strap),
      .clk_in(clk_in), .avs_req(req), .avs_waitrequest(wait_r), .avs_readdata(rdata),
      .debug_clock_output_o(dbg), .debug_clock_output_oe(oe), .gen_ref_clk(gref),
      .rtc_timer_clk(rtc), .pll_bypass(byp), .pll_mult(mult),
      .clock_output_slew_control(slew), .spi_clk_div(spi), .i2c_clk_div(i2c));

   // Clock and a record of the clock levels seen at the last two edges.
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      h2 <= h1;
      h1 <= clk_in;
   end

   // ****************************************************************
   // Tasks
   // ****************************************************************
   task stop_test;
      $display("mismatches %0d, comparisons %0d", n_mismatch, checked);
      if (n_mismatch == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : stop_test

   // Exact comparison; an unknown value never passes.
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One Avalon access, held until waitrequest is sampled low.
   task bus(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
      @(posedge sys_clk);
      req <= '{~wr, wr, 16'(idx << 2), wd};
      @(posedge sys_clk);
      while (wait_r !== 1'b0) begin
         @(posedge sys_clk);
      end
      rd = rdata;
      req <= '0;
   endtask : bus

   // Reset for three cycles with the given strap, then follow the boot.
   task rst(input logic s);
      sys_rst <= 1'b1;
      strap_level <= s;
      repeat (3) @(posedge sys_clk);
      sys_rst <= 1'b0;
      repeat (2) @(negedge sys_clk);
      chk(oe, 1);
      repeat (3) @(negedge sys_clk);
      chk(oe, 0);
      repeat (2) @(negedge sys_clk);
   endtask : rst

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      rst(1'b0);
      chk(byp, 1'b0);
      chk({spi, i2c}, 32'h0);
      chk(mult, 12'h001);
      for (int i = 0; i < 11; i++) begin
         if (rows[i].wr) bus(1'b1, rows[i].idx, rows[i].wd);
         bus(1'b0, rows[i].idx, 32'h0);
         chk(rd, rows[i].ex);
      end
      chk(oe, 1);
      chk(slew, 16'h1234);
      chk(mult, 12'he4e);
      // Every source code, with the oscillator as the generator reference.
      for (int s = 0; s < 4; s++) begin
         bus(1'b1, SRC_REG_IDX, 32'(s));
         repeat (2) @(negedge sys_clk);
         for (int k = 0; k < 8; k++) begin
            @(negedge sys_clk);
            // Code 1 passes the generator reference, itself one register behind.
            chk(dbg, (s == 1) ? h2.osc_32k : (s[1] ? h1.pll_out : h1.osc_32k));
            chk({gref, rtc}, {h1.osc_32k, h1.osc_32k});
         end
      end
      bus(1'b1, STATUS3_IDX, 32'h1);
      repeat (2) @(negedge sys_clk);
      chk(oe, 0);
      // Second reset in mid-run with the external reference selected.
      @(posedge sys_clk);
      rst(1'b1);
      chk(byp, 1'b1);
      chk({spi, i2c}, {16'h0017, 16'h001d});
      // Code 3 follows the bypassed reference once boot has set the bypass.
      bus(1'b1, SRC_REG_IDX, 32'h3);
      repeat (2) @(negedge sys_clk);
      for (int k = 0; k < 8; k++) begin
         @(negedge sys_clk);
         chk({gref, rtc}, {h1.ext_ref, h1.osc_32k});
         chk(dbg, h2.ext_ref);
      end
      bus(1'b0, SLEW_CTRL_IDX, 32'h0);
      chk(rd, 32'h0);
      bus(1'b1, PLL_CFG_IDX, 32'h1fff);
      bus(1'b0, PLL_CFG_IDX, 32'h0);
      chk(rd, 32'h100a);
      chk(mult, 12'h00a);
      stop_test();
   end

   // Watchdog far beyond the roughly 150 cycles the run needs.
   initial begin
      #20000;
      n_mismatch++;
      stop_test();
   end
endmodule : tb_cssd_top
